// ==== rtl/urx_pkg.sv ====
package urx_pkg;

  // register indices on the plain register port
  localparam logic [3:0] OFS_RX_STAT_CTRL  = 4'h0;
  localparam logic [3:0] OFS_RX_DATA       = 4'h1;
  localparam logic [3:0] OFS_DIV_LOW       = 4'h2;
  localparam logic [3:0] OFS_DIV_HIGH      = 4'h3;
  localparam logic [3:0] OFS_TX_STAT_CTRL  = 4'h4;
  localparam logic [3:0] OFS_BAUD_CTRL     = 4'h5;
  localparam logic [3:0] OFS_PERIPH_FLAGS  = 4'h6;
  localparam logic [3:0] OFS_PERIPH_ENABLE = 4'h7;
  localparam logic [3:0] OFS_CORE_IRQ_CTRL = 4'h8;
  localparam logic [3:0] OFS_EVT_STATUS    = 4'h9;
  localparam logic [3:0] OFS_EVT_MASK      = 4'hA;

  // field positions
  localparam int BIT_SERIAL_PORT_EN  = 7;
  localparam int BIT_NINE_BIT_RX     = 6;
  localparam int BIT_CONT_RX_EN      = 4;
  localparam int BIT_FRAMING_ERR     = 2;
  localparam int BIT_OVERRUN_ERR     = 1;
  localparam int BIT_NINTH_DATA      = 0;
  localparam int BIT_SYNC_MODE       = 4;
  localparam int BIT_HIGH_SPEED      = 2;
  localparam int BIT_RX_IDLE         = 6;
  localparam int BIT_WIDE_DIVISOR    = 3;
  localparam int BIT_RX_PENDING      = 5;
  localparam int BIT_RX_IRQ_EN       = 5;
  localparam int BIT_GLOBAL_IRQ_EN   = 7;
  localparam int BIT_PERIPH_IRQ_EN   = 6;
  localparam int EVT_CHAR            = 0;
  localparam int EVT_FRAMING         = 1;
  localparam int EVT_OVERRUN         = 2;

  // writable masks and reset values
  localparam logic [7:0] RX_CTRL_WMASK   = 8'hF8;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h1B;
  localparam logic [7:0] EVT_WMASK       = 8'h07;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // divisor scaling, as left shifts of (n+1)
  localparam logic [2:0] SH_FACTOR_64 = 3'h6;
  localparam logic [2:0] SH_FACTOR_16 = 3'h4;
  localparam logic [2:0] SH_FACTOR_4  = 3'h2;

  // oversampling and mid-bit voting points
  localparam logic [22:0] OVERSAMPLE  = 23'h000010;
  localparam logic [3:0]  VOTE_FIRST  = 4'h7;
  localparam logic [3:0]  VOTE_SECOND = 4'h8;
  localparam logic [3:0]  VOTE_LAST   = 4'h9;

  typedef enum logic [1:0] {
    URX_IDLE  = 2'b00,
    URX_START = 2'b01,
    URX_DATA  = 2'b10,
    URX_STOP  = 2'b11
  } urx_state_t;

  typedef struct packed {
    logic       framing_err;
    logic       ninth;
    logic [7:0] data;
  } urx_char_t;

endpackage

// ==== rtl/urx_receiver.sv ====
`timescale 1ns/1ps
// What this block does
// - a falling edge on the line starts a character; first bit is start
// - half a bit later the line must still be low to go on
// - high at mid start bit: abort quietly, no error, wait for edge
// - each data bit sampled mid-bit by majority vote, shifted in
// - stop bit sampled a bit later; zero sets, one clears framing error
// - completed character goes to the queue and the pending flag rises
// - reading receive data returns and removes the oldest character
// - after queue overrun nothing more is received until cleared
// - pending flag is high when enabled and a character is unread
// - pending flag is read-only; writes to its register never touch it
// - receive interrupt needs receive, peripheral and global enables
// - bit rate is clock over 64, 16 or 4 times divisor plus one, at most clock over 16
// - line oversampled at 16 times bit rate; shifter moves once a bit
// - queue holds two characters while a third is shifted in
module urx_receiver
  import urx_pkg::*;
#(
  parameter int QUEUE_DEPTH = 2
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_in,
  output logic            rx_irq_req,
  output logic            irq
);
  import urx_pkg::*;

  localparam int PW = $clog2(QUEUE_DEPTH);

  // register storage
  logic [7:0]  rx_ctrl_ff;
  logic [7:0]  div_low_ff;
  logic [7:0]  div_high_ff;
  logic [7:0]  tx_ctrl_ff;
  logic [7:0]  baud_ctrl_ff;
  logic [7:0]  periph_en_ff;
  logic [7:0]  core_irq_ff;
  logic [7:0]  evt_sts_ff;
  logic [7:0]  evt_mask_ff;
  logic        overrun_ff;
  logic [7:0]  rdata_ff;

  // line and timing
  logic        sync1_ff;
  logic        sync2_ff;
  logic        sync3_ff;
  logic        line_ff;
  logic [22:0] acc_ff;
  logic [3:0]  tick_cnt_ff;
  logic [3:0]  bit_cnt_ff;
  logic [1:0]  vote_ff;
  logic [8:0]  shift_ff;
  urx_state_t  state_ff;

  // queue
  urx_char_t   queue_ff [QUEUE_DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] count_ff;

  // decode
  wire wr_rx_ctrl  = reg_wr && (reg_addr == OFS_RX_STAT_CTRL);
  wire rd_rx_data  = reg_rd && (reg_addr == OFS_RX_DATA);
  wire wr_evt_sts  = reg_wr && (reg_addr == OFS_EVT_STATUS);

  wire serial_port_enable        = rx_ctrl_ff[BIT_SERIAL_PORT_EN];
  wire continuous_receive_enable = rx_ctrl_ff[BIT_CONT_RX_EN];
  wire nine_bit                  = rx_ctrl_ff[BIT_NINE_BIT_RX];
  wire sync_mode                 = tx_ctrl_ff[BIT_SYNC_MODE];
  wire high_speed_select         = tx_ctrl_ff[BIT_HIGH_SPEED];
  wire wide_divisor_select       = baud_ctrl_ff[BIT_WIDE_DIVISOR];
  // software opens reception with these three bits
  wire rx_enable = serial_port_enable && continuous_receive_enable
                   && !sync_mode;

  // baud generator: ticks at 16x bit rate from an accumulator, so the
  // factor-4 modes keep their average rate for divisors of 3 and up; at most one tick per clock
  wire [16:0] div_plus1 = wide_divisor_select
                          ? {1'b0, div_high_ff, div_low_ff} + 17'h00001
                          : {9'h000, div_low_ff} + 17'h00001;
  wire [2:0]  factor_sh = sync_mode ? SH_FACTOR_4 :
                          wide_divisor_select
                            ? (high_speed_select ? SH_FACTOR_4
                                                 : SH_FACTOR_16)
                            : (high_speed_select ? SH_FACTOR_16
                                                 : SH_FACTOR_64);
  wire [22:0] bit_clocks = {6'h00, div_plus1} << factor_sh;
  wire [22:0] acc_sum    = acc_ff + OVERSAMPLE;
  wire        os_tick    = acc_sum >= bit_clocks;
  wire [22:0] acc_next   = os_tick ? acc_sum - bit_clocks : acc_sum;

  // stable line: accepted once second and third stages agree
  wire line_agree = sync2_ff == sync3_ff;
  wire line_now   = line_agree ? sync3_ff : line_ff;
  wire fall_edge  = line_ff && line_agree && !sync3_ff;

  // majority of three samples around mid-bit
  wire at_vote  = os_tick && (tick_cnt_ff == VOTE_LAST);
  wire bit_val  = (vote_ff[0] & vote_ff[1]) | (vote_ff[0] & line_now)
                  | (vote_ff[1] & line_now);
  wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;

  // queue handshake
  wire q_full   = count_ff == (PW+1)'(QUEUE_DEPTH);
  wire q_empty  = count_ff == '0;
  wire pop      = rd_rx_data && !q_empty;
  wire finish   = (state_ff == URX_STOP) && at_vote;
  wire push_try = finish && rx_enable;
  wire push     = push_try && (!q_full || pop);
  wire overflow = push_try && q_full && !pop;
  wire stop_err = !line_now;
  urx_char_t in_char;
  assign in_char = '{framing_err: stop_err,
                     ninth: nine_bit ? shift_ff[8] : 1'b0,
                     data: nine_bit ? shift_ff[7:0] : shift_ff[8:1]};
  urx_char_t top_char;
  assign top_char = q_empty ? '0 : queue_ff[rptr_ff];

  // pending flag follows the queue and the serial port enable only
  wire rx_pending_flag = serial_port_enable && !q_empty;

  // next state of the receiver
  urx_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      URX_IDLE: begin
        if (fall_edge && rx_enable && !overrun_ff) begin
          nxt_state = URX_START;
        end
      end
      URX_START: begin
        if (at_vote) begin
          nxt_state = bit_val ? URX_IDLE : URX_DATA;
        end
      end
      URX_DATA: begin
        if (at_vote && bit_cnt_ff == last_bit) begin
          nxt_state = URX_STOP;
        end
      end
      URX_STOP: begin
        if (at_vote) begin
          nxt_state = URX_IDLE;
        end
      end
    endcase
    if (!rx_enable) begin
      nxt_state = URX_IDLE;
    end
  end

  // synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      line_ff  <= 1'b1;
    end else begin
      sync1_ff <= rx_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      line_ff  <= line_now;
    end
  end

  // bit timing: counters restart at the falling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff      <= '0;
      tick_cnt_ff <= '0;
      vote_ff     <= '0;
    end else if (state_ff == URX_IDLE) begin
      acc_ff      <= '0;
      tick_cnt_ff <= '0;
    end else begin
      acc_ff <= acc_next;
      if (os_tick) begin
        tick_cnt_ff <= tick_cnt_ff + 4'h1;
        if (tick_cnt_ff == VOTE_FIRST) vote_ff[0] <= line_now;
        if (tick_cnt_ff == VOTE_SECOND) vote_ff[1] <= line_now;
      end
    end
  end

  // receive shift register and bit count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= URX_IDLE;
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == URX_START) begin
        bit_cnt_ff <= '0;
      end else if (state_ff == URX_DATA && at_vote) begin
        shift_ff   <= {bit_val, shift_ff[8:1]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end
  end

  // two-entry queue
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else if (!serial_port_enable) begin
      wptr_ff  <= '0;
      rptr_ff  <= '0;
      count_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + PW'(1);
      if (pop) rptr_ff <= rptr_ff + PW'(1);
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          queue_ff[gi] <= '0;
        end else if (push && wptr_ff == PW'(gi)) begin
          queue_ff[gi] <= in_char;
        end
      end
    end
  endgenerate

  // overrun holds off reception; cleared by dropping continuous receive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (overflow) begin
      overrun_ff <= 1'b1;
    end else if (!continuous_receive_enable || !serial_port_enable) begin
      overrun_ff <= 1'b0;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  wire [7:0] evt_set = {5'h00, overflow, push && stop_err, push};
  wire [7:0] evt_clr = wr_evt_sts ? (reg_wdata & EVT_WMASK) : 8'h00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_sts_ff <= RST_BYTE;
    end else begin
      evt_sts_ff <= (evt_sts_ff & ~evt_clr) | evt_set;
    end
  end

  // software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_ff   <= RST_BYTE;
      div_low_ff   <= RST_BYTE;
      div_high_ff  <= RST_BYTE;
      tx_ctrl_ff   <= RST_BYTE;
      baud_ctrl_ff <= RST_BYTE;
      periph_en_ff <= RST_BYTE;
      core_irq_ff  <= RST_BYTE;
      evt_mask_ff  <= RST_BYTE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_RX_STAT_CTRL:  rx_ctrl_ff   <= reg_wdata & RX_CTRL_WMASK;
        OFS_DIV_LOW:       div_low_ff   <= reg_wdata;
        OFS_DIV_HIGH:      div_high_ff  <= reg_wdata;
        OFS_TX_STAT_CTRL:  tx_ctrl_ff   <= reg_wdata;
        OFS_BAUD_CTRL:     baud_ctrl_ff <= reg_wdata & BAUD_CTRL_WMASK;
        OFS_PERIPH_ENABLE: periph_en_ff <= reg_wdata;
        OFS_CORE_IRQ_CTRL: core_irq_ff  <= reg_wdata;
        OFS_EVT_MASK:      evt_mask_ff  <= reg_wdata & EVT_WMASK;
        default: ;
      endcase
    end
  end

  // read mux; framing and ninth-bit flags come from the oldest queued character
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      OFS_RX_STAT_CTRL: begin
        rd_mux = rx_ctrl_ff;
        rd_mux[BIT_FRAMING_ERR] = top_char.framing_err;
        rd_mux[BIT_OVERRUN_ERR] = overrun_ff;
        rd_mux[BIT_NINTH_DATA]  = top_char.ninth;
      end
      OFS_RX_DATA:       rd_mux = top_char.data;
      OFS_DIV_LOW:       rd_mux = div_low_ff;
      OFS_DIV_HIGH:      rd_mux = div_high_ff;
      OFS_TX_STAT_CTRL:  rd_mux = tx_ctrl_ff;
      OFS_BAUD_CTRL: begin
        rd_mux = baud_ctrl_ff;
        rd_mux[BIT_RX_IDLE] = state_ff == URX_IDLE;
      end
      OFS_PERIPH_FLAGS: begin
        rd_mux[BIT_RX_PENDING] = rx_pending_flag;
      end
      OFS_PERIPH_ENABLE: rd_mux = periph_en_ff;
      OFS_CORE_IRQ_CTRL: rd_mux = core_irq_ff;
      OFS_EVT_STATUS:    rd_mux = evt_sts_ff;
      OFS_EVT_MASK:      rd_mux = evt_mask_ff;
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign rx_irq_req = rx_pending_flag && periph_en_ff[BIT_RX_IRQ_EN]
                      && core_irq_ff[BIT_PERIPH_IRQ_EN]
                      && core_irq_ff[BIT_GLOBAL_IRQ_EN];
  assign irq        = |(evt_sts_ff & evt_mask_ff);

endmodule

// ==== dv/urx_line_tx.sv ====
`timescale 1ns/1ps
// far-end transmitter; line idles high, drives only what the bench asks
module urx_line_tx (
  input  wire logic clk,
  output logic      line
);
  initial line = 1'b1;

  task automatic send(input logic [8:0] d, input int nb, input int bt,
                      input logic stp);
    line <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (bt) @(posedge clk);
    end
    line <= stp;
    repeat (bt) @(posedge clk);
    line <= 1'b1;
  endtask

  // short low pulse, gone before mid start bit
  task automatic blip(input int w);
    line <= 1'b0;
    repeat (w) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule

// ==== dv/urx_receiver_properties.sv ====
`timescale 1ns/1ps
module urx_receiver_properties
  import urx_pkg::*;
#(
  parameter int QUEUE_DEPTH = 2
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_in,
  input wire logic       rx_irq_req,
  input wire logic       irq
);
  logic       rie_ff;
  logic       core_ff;
  logic [7:0] msk_ff;
  // shadows of the enables, so gating is judged apart from the design
  wire        wr_pie = reg_wr && reg_addr == OFS_PERIPH_ENABLE;
  wire        wr_core = reg_wr && reg_addr == OFS_CORE_IRQ_CTRL;
  wire        wr_msk = reg_wr && reg_addr == OFS_EVT_MASK;
  wire        gates = rie_ff && core_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rie_ff  <= 1'b0;
      core_ff <= 1'b0;
      msk_ff  <= 8'h00;
    end else begin
      if (wr_pie) rie_ff <= reg_wdata[BIT_RX_IRQ_EN];
      if (wr_core) core_ff <= &reg_wdata[7:6];
      if (wr_msk) msk_ff <= reg_wdata & EVT_WMASK;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  unmapped_rd_a: assert property (reg_rd && reg_addr > OFS_EVT_MASK
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_gate_a: assert property (rx_irq_req |-> gates)
    else $error("receive request with an enable clear");
  req_fall_a: assert property ($fell(rx_irq_req) |-> $past(reg_rd &&
    reg_addr == OFS_RX_DATA || wr_pie || wr_core || reg_wr &&
    (reg_addr == OFS_RX_STAT_CTRL || reg_addr == OFS_TX_STAT_CTRL)))
    else $error("receive request dropped without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_msk || reg_wr &&
    reg_addr == OFS_EVT_STATUS)) else $error("irq dropped without write");
  irq_mask_a: assert property (irq |-> msk_ff != 8'h00)
    else $error("irq high with all events masked");
  pend_read_a: assert property (reg_rd && reg_addr == OFS_PERIPH_FLAGS
    && gates |=> reg_rdata[BIT_RX_PENDING] == $past(rx_irq_req))
    else $error("pending bit disagrees with request");
  flag_ro_a: assert property (reg_wr && reg_addr == OFS_PERIPH_FLAGS
    && rx_irq_req |=> rx_irq_req) else $error("flag write cleared pending");
endmodule

bind urx_receiver urx_receiver_properties #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_u (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in),
  .rx_irq_req(rx_irq_req), .irq(irq));

// ==== dv/tb_async_uart_receiver_brg.sv ====
`timescale 1ns/1ps
module tb_async_uart_receiver_brg;
  import urx_pkg::*;
  logic       clk, rst_n, reg_wr, reg_rd, rx_line, rx_irq_req, irq, ovr;
  logic       gate, sync;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ctl, msk, evt;
  logic [9:0] q[$];
  int         error_cnt, checked, seed, bt;
  // rows: slow wide first, fastest last to keep later tests short
  localparam logic [7:0] TXV [4] = '{8'h04, 8'h00, 8'h00, 8'h04};
  localparam logic [7:0] BDV [4] = '{8'h08, 8'h00, 8'h08, 8'h00};
  localparam logic [7:0] LOV [4] = '{8'h0F, 8'h01, 8'h05, 8'h02};
  localparam logic [7:0] HIV [4] = '{8'h01, 8'h05, 8'h00, 8'h05};
  localparam int         BTV [4] = '{1088, 128, 96, 48};
  localparam logic [3:0] GA [3] = '{OFS_PERIPH_ENABLE, OFS_CORE_IRQ_CTRL,
                                    OFS_CORE_IRQ_CTRL};
  localparam logic [7:0] GV [3] = '{8'h00, 8'h80, 8'h40};
  localparam logic [7:0] GR [3] = '{8'h20, 8'hC0, 8'hC0};

  urx_receiver dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_in(rx_line), .rx_irq_req(rx_irq_req),
    .irq(irq));
  urx_line_tx tx_u (.clk(clk), .line(rx_line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask

  function automatic logic [7:0] st0();
    logic [7:0] v;
    v = ctl | {6'h00, ovr, 1'b0};
    if (q.size() != 0) v = v | {5'h00, q[0][9], 1'b0, q[0][8]};
    return v;
  endfunction

  task automatic look();
    rd(OFS_PERIPH_FLAGS, (q.size() != 0) ? 8'h20 : 8'h00);
    rd(OFS_RX_STAT_CTRL, st0());
    rd(OFS_EVT_STATUS, evt);
    chk({7'h00, irq}, {7'h00, |(evt & msk)});
    chk({7'h00, rx_irq_req}, {7'h00, q.size() != 0 && gate});
  endtask

  task automatic pop();
    logic [7:0] e;
    e = 8'h00;
    if (q.size() != 0) e = 8'(q.pop_front());
    rd(OFS_RX_DATA, e);
  endtask

  task automatic frame(input logic [8:0] d, input logic stp);
    int nb;
    nb = ctl[BIT_NINE_BIT_RX] ? 9 : 8;
    tx_u.send(d, nb, bt, stp);
    repeat (8) @(posedge clk);
    if (ctl[BIT_SERIAL_PORT_EN] && ctl[BIT_CONT_RX_EN] && !sync && !ovr) begin
      if (q.size() < 2) begin
        q.push_back({~stp, nb == 9 && d[8], d[7:0]});
        evt = evt | {6'h00, ~stp, 1'b1};
      end else begin
        ovr = 1'b1;
        evt = evt | 8'h04;
      end
    end
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {error_cnt, checked, ovr, gate, sync, evt} = '0;
    seed = 32'h7456;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), (a == 5) ? 8'h40 : 8'h00);
    $display("reset values done");
    ctl = 8'h90;
    wr(OFS_RX_STAT_CTRL, ctl);
    wr(OFS_PERIPH_ENABLE, 8'h20);
    wr(OFS_CORE_IRQ_CTRL, 8'hC0);
    msk = 8'h07;
    wr(OFS_EVT_MASK, msk);
    gate = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_TX_STAT_CTRL, TXV[m]);
      wr(OFS_BAUD_CTRL, BDV[m]);
      wr(OFS_DIV_LOW, LOV[m]);
      wr(OFS_DIV_HIGH, HIV[m]);
      bt = BTV[m];
      frame(9'($random(seed)), 1'b1);
      look();
      pop();
      look();
    end
    $display("divisor modes done");
    frame(9'($random(seed)), 1'b0);
    msk = 8'h00;
    wr(OFS_EVT_MASK, msk);
    look();
    msk = 8'h07;
    wr(OFS_EVT_MASK, msk);
    wr(OFS_PERIPH_FLAGS, 8'h00);
    look();
    for (int g = 0; g < 3; g++) begin
      gate = 1'b0;
      wr(GA[g], GV[g]);
      look();
      gate = 1'b1;
      wr(GA[g], GR[g]);
    end
    pop();
    evt = 8'h00;
    wr(OFS_EVT_STATUS, 8'h07);
    look();
    $display("framing and interrupt done");
    tx_u.blip(bt / 4);
    repeat (12 * bt) @(posedge clk);
    look();
    ctl = 8'hD0;
    wr(OFS_RX_STAT_CTRL, ctl);
    frame(9'h1A5, 1'b1);
    look();
    pop();
    ctl = 8'h90;
    wr(OFS_RX_STAT_CTRL, ctl);
    repeat (4) frame(9'($random(seed)), 1'b1);
    look();
    pop();
    pop();
    look();
    ovr = 1'b0;
    wr(OFS_RX_STAT_CTRL, 8'h80);
    wr(OFS_RX_STAT_CTRL, ctl);
    evt = 8'h00;
    wr(OFS_EVT_STATUS, 8'h07);
    frame(9'($random(seed)), 1'b1);
    look();
    pop();
    $display("abort, nine bit and overrun done");
    sync = 1'b1;
    wr(OFS_TX_STAT_CTRL, 8'h14);
    frame(9'($random(seed)), 1'b1);
    look();
    $display("sync mode done");
    end_of_test();
  end
endmodule
